// ---- hw/loc_overlay_char_gen_ram.sv ----
// Layer overlay control, composition and character generator start address
// Functional notes
// - Overlay command parameter loads overlay control exactly like a direct write.
// - Bit 3 clear puts screen block 3 in text, set in graphics.
// - Bit 2 clear puts screen block 1 in text, set in graphics.
// - Bits 1-0 choose OR, XOR or AND composition.
// - Field 00: output is OR of all three layers.
// - Field 01: first XOR second, then OR third.
// - Field 10: first AND second, then OR third; 11 reserved.
// - One method per layer, shared by both blocks of a layer.
// - Text first layer excludes the third layer from the image.
// - Second layer is graphics only.
// - Third layer is graphics only.
// - Address command takes low then high byte into start registers.
// - Low register holds start address bits 7-0.
`timescale 1ns/1ps
`include "loc_defines.svh"

module loc_overlay_chargen #(
  parameter int PIX_W  = 1,
  parameter int CODE_W = 8,
  parameter int HGT_W  = 5
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [15:0]       reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              cmd_wr_i,
  input  wire logic [7:0]        cmd_code_i,
  input  wire logic              prm_wr_i,
  input  wire logic [7:0]        prm_data_i,
  input  wire logic [PIX_W-1:0]  first_pix_i,
  input  wire logic              first_from_blk3_i,
  input  wire logic [PIX_W-1:0]  second_pix_i,
  input  wire logic [PIX_W-1:0]  third_pix_i,
  output logic      [PIX_W-1:0]  comp_pix_o,
  input  wire logic [CODE_W-1:0] char_code_i,
  input  wire logic [HGT_W-1:0]  char_height_i,
  output logic      [15:0]       cg_addr_o,
  output logic                   blk1_graphics_o,
  output logic                   blk2_graphics_o,
  output logic                   blk3_graphics_o,
  output logic                   blk4_graphics_o,
  output logic                   three_layer_o,
  output logic                   second_text_o,
  output logic                   third_text_o
);

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Merge three layer pixels with the selected method
  function automatic logic [PIX_W-1:0] compose(
    input logic [1:0]       sel,
    input logic [PIX_W-1:0] a,
    input logic [PIX_W-1:0] b,
    input logic [PIX_W-1:0] c
  );
    logic [PIX_W-1:0] r;
    r = '0;
    case (sel)
      loc_pkg::LOC_COMP_OR:  r = a | b | c;
      loc_pkg::LOC_COMP_XOR: r = (a ^ b) | c;
      loc_pkg::LOC_COMP_AND: r = (a & b) | c;
      default:             r = a | b | c; // Reserved code falls back to OR
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]              ovl_r, ovl_nxt;
  logic [7:0]              cg_lo_r, cg_lo_nxt;
  logic [7:0]              cg_hi_r, cg_hi_nxt;
  logic [15:0]             cg_start_r, cg_start_nxt;
  logic [7:0]              rdata_nxt;
  loc_pkg::loc_state_t     st_r, st_nxt;
  logic                    ovl_load;
  logic                    lo_load;
  logic                    hi_load;
  logic [7:0]              ovl_val;
  logic [7:0]              lo_val;
  logic [7:0]              hi_val;

  // Direct and indirect load sources
  always_comb begin
    ovl_load = 1'b0;
    lo_load  = 1'b0;
    hi_load  = 1'b0;
    ovl_val  = reg_wdata_i;
    lo_val   = reg_wdata_i;
    hi_val   = reg_wdata_i;
    st_nxt   = st_r;
    if (reg_wr_i) begin
      ovl_load = (reg_addr_i == `LOC_OFF_OVL_CTRL);
      lo_load  = (reg_addr_i == `LOC_OFF_CG_LOW);
      hi_load  = (reg_addr_i == `LOC_OFF_CG_HIGH);
    end
    if (cmd_wr_i) begin
      if (cmd_code_i == `LOC_CMD_OVERLAY) begin
        st_nxt = loc_pkg::LOC_ST_OVL;
      end else if (cmd_code_i == `LOC_CMD_CG_ADDR) begin
        st_nxt = loc_pkg::LOC_ST_CG_LO;
      end else begin
        st_nxt = loc_pkg::LOC_ST_IDLE;
      end
    end else if (prm_wr_i) begin
      case (st_r)
        loc_pkg::LOC_ST_OVL: begin
          ovl_load = 1'b1;
          ovl_val  = prm_data_i;
          st_nxt   = loc_pkg::LOC_ST_IDLE;
        end
        loc_pkg::LOC_ST_CG_LO: begin
          lo_load = 1'b1;
          lo_val  = prm_data_i;
          st_nxt  = loc_pkg::LOC_ST_CG_HI;
        end
        loc_pkg::LOC_ST_CG_HI: begin
          hi_load = 1'b1;
          hi_val  = prm_data_i;
          st_nxt  = loc_pkg::LOC_ST_IDLE;
        end
        loc_pkg::LOC_ST_IDLE: st_nxt = loc_pkg::LOC_ST_IDLE;
        default:              st_nxt = loc_pkg::LOC_ST_IDLE;
      endcase
    end
  end

  // Next register values
  always_comb begin
    ovl_nxt      = ovl_r;
    cg_lo_nxt    = cg_lo_r;
    cg_hi_nxt    = cg_hi_r;
    cg_start_nxt = cg_start_r;
    if (ovl_load) begin
      ovl_nxt = ovl_val & `LOC_OVL_USED_MASK;
    end
    if (lo_load) begin
      cg_lo_nxt = lo_val;
    end
    if (hi_load) begin
      cg_hi_nxt    = hi_val;
      cg_start_nxt = {hi_val, lo_load ? lo_val : cg_lo_r};
    end
    rdata_nxt = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LOC_OFF_OVL_CTRL: rdata_nxt = ovl_r;
        `LOC_OFF_CG_LOW:   rdata_nxt = cg_lo_r;
        `LOC_OFF_CG_HIGH:  rdata_nxt = cg_hi_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // Register update
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovl_r       <= `LOC_RST_OVL_CTRL;
      cg_lo_r     <= `LOC_RST_CG_LOW;
      cg_hi_r     <= `LOC_RST_CG_HIGH;
      cg_start_r  <= {`LOC_RST_CG_HIGH, `LOC_RST_CG_LOW};
      st_r        <= loc_pkg::LOC_ST_IDLE;
      reg_rdata_o <= 8'h00;
    end else begin
      ovl_r       <= ovl_nxt;
      cg_lo_r     <= cg_lo_nxt;
      cg_hi_r     <= cg_hi_nxt;
      cg_start_r  <= cg_start_nxt;
      st_r        <= st_nxt;
      reg_rdata_o <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic       first_text;
  logic       use_third;
  logic [1:0] comp_sel;

  assign blk1_graphics_o = ovl_r[`LOC_BIT_BLK1_MODE];
  assign blk3_graphics_o = ovl_r[`LOC_BIT_BLK3_MODE];
  assign blk2_graphics_o = 1'b1;
  assign blk4_graphics_o = 1'b1;
  assign three_layer_o   = ovl_r[`LOC_BIT_THREE_LYR];
  assign second_text_o   = 1'b0;
  assign third_text_o    = 1'b0;
  // one method for the whole layer
  assign comp_sel        = ovl_r[`LOC_COMP_MSB:`LOC_COMP_LSB];
  assign first_text = first_from_blk3_i ? !ovl_r[`LOC_BIT_BLK3_MODE]
                                        : !ovl_r[`LOC_BIT_BLK1_MODE];
  // text first layer drops third layer
  assign use_third  = ovl_r[`LOC_BIT_THREE_LYR] && !first_text;

  //////////////////////////////////////////////////////////////////////////
  // Pixel composition and pattern address

  logic [PIX_W-1:0] comp_nxt;
  logic [15:0]      cg_addr_nxt;
  logic [15:0]      prod;

  always_comb begin
    comp_nxt    = compose(comp_sel, first_pix_i, second_pix_i,
                          use_third ? third_pix_i : {PIX_W{1'b0}});
    prod        = 16'(char_code_i * char_height_i);
    cg_addr_nxt = 16'(prod + cg_start_r);
  end

  // Output registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_pix_o <= '0;
      cg_addr_o  <= 16'h0000;
    end else begin
      comp_pix_o <= comp_nxt;
      cg_addr_o  <= cg_addr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  a_ovl_cmd_load : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) st_r == loc_pkg::LOC_ST_OVL && prm_wr_i &&
    !cmd_wr_i |=> ovl_r == ($past(prm_data_i) & `LOC_OVL_USED_MASK))
    else $error("overlay parameter not loaded");

  a_blk3_mode : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) blk3_graphics_o == ovl_r[3])
    else $error("block 3 mode mismatch");

  a_blk1_mode : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) blk1_graphics_o == ovl_r[2])
    else $error("block 1 mode mismatch");

  a_even_blk_graphics : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    blk2_graphics_o && blk4_graphics_o && !second_text_o && !third_text_o)
    else $error("blocks 2 and 4 not graphics");

  a_or_compose : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) (comp_sel == 2'h0 && use_third) |=> comp_pix_o ==
    ($past(first_pix_i) | $past(second_pix_i) | $past(third_pix_i)))
    else $error("OR composition wrong");

  a_xor_compose : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) (comp_sel == 2'h1 && !use_third) |=>
    comp_pix_o == ($past(first_pix_i) ^ $past(second_pix_i)))
    else $error("XOR composition wrong");

  a_and_compose : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) (comp_sel == 2'h2 && use_third) |=> comp_pix_o ==
    (($past(first_pix_i) & $past(second_pix_i)) | $past(third_pix_i)))
    else $error("AND composition wrong");

  a_text_no_third : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) (!first_from_blk3_i && !ovl_r[2]) |-> !use_third)
    else $error("third layer used with text");

  a_cg_high_commit : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (lo_load && !hi_load) |=> cg_start_r == $past(cg_start_r))
    else $error("start changed on low write");

  a_cg_addr_calc : assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) !hi_load |=> cg_addr_o ==
    16'($past(char_code_i) * $past(char_height_i) + cg_start_r))
    else $error("pattern address wrong");

endmodule

// ---- hw/loc_defines.svh ----
// Offsets, field positions, reset values and command codes of the overlay block
`ifndef LOC_DEFINES_SVH
`define LOC_DEFINES_SVH

// Direct register addresses
`define LOC_OFF_OVL_CTRL   16'h8018
`define LOC_OFF_CG_LOW     16'h8019
`define LOC_OFF_CG_HIGH    16'h801A

// Overlay control fields
`define LOC_BIT_THREE_LYR  4
`define LOC_BIT_BLK3_MODE  3
`define LOC_BIT_BLK1_MODE  2
`define LOC_COMP_MSB       1
`define LOC_COMP_LSB       0
`define LOC_OVL_USED_MASK  8'h1F

// Reset values
`define LOC_RST_OVL_CTRL   8'h00
`define LOC_RST_CG_LOW     8'h00
`define LOC_RST_CG_HIGH    8'h00

// Indirect command codes
`define LOC_CMD_OVERLAY    8'hA1
`define LOC_CMD_CG_ADDR    8'hA2

`endif

// ---- hw/loc_pkg.sv ----
// Types shared by the overlay and character generator configuration block
package loc_pkg;

  // Composition method encodings
  typedef enum logic [1:0] {
    LOC_COMP_OR   = 2'h0,
    LOC_COMP_XOR  = 2'h1,
    LOC_COMP_AND  = 2'h2,
    LOC_COMP_RSVD = 2'h3
  } loc_comp_t;

  // Indirect parameter sequencer states
  typedef enum logic [3:0] {
    LOC_ST_IDLE  = 4'h1,
    LOC_ST_OVL   = 4'h2,
    LOC_ST_CG_LO = 4'h4,
    LOC_ST_CG_HI = 4'h8
  } loc_state_t;

endpackage

// ---- tb/loc_host_model.sv ----
// Host model driving the direct register and indirect command ports
`timescale 1ns/1ps

module loc_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [7:0]  reg_rdata_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [15:0]      reg_addr_o,
  output logic [7:0]       reg_wdata_o,
  output logic             cmd_wr_o,
  output logic [7:0]       cmd_code_o,
  output logic             prm_wr_o,
  output logic [7:0]       prm_data_o
);
  // Idle bus at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 16'h0000;
    reg_wdata_o = 8'h00;
    cmd_wr_o    = 1'b0;
    cmd_code_o  = 8'h00;
    prm_wr_o    = 1'b0;
    prm_data_o  = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // caller orders bytes
  // Direct write; released data is inverted so stale values never help
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask

  // Direct read; data taken one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask

  task automatic cmd(input logic [7:0] c);
    @(posedge sys_clk_i);
    cmd_wr_o   <= 1'b1;
    cmd_code_o <= c;
    @(posedge sys_clk_i);
    cmd_wr_o   <= 1'b0;
    cmd_code_o <= ~c;
  endtask

  task automatic prm(input logic [7:0] d);
    @(posedge sys_clk_i);
    prm_wr_o   <= 1'b1;
    prm_data_o <= d;
    @(posedge sys_clk_i);
    prm_wr_o   <= 1'b0;
    prm_data_o <= ~d;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the overlay and start address block
`timescale 1ns/1ps
`include "loc_defines.svh"

module tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        reg_wr, reg_rd, cmd_wr, prm_wr;
  logic [15:0] reg_addr, cg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cmd_code, prm_data, rv;
  logic        px1 = 1'b0, px2 = 1'b0, px3 = 1'b0, blk3_src = 1'b0;
  logic        comp_pix, b1_g, b2_g, b3_g, b4_g, three, t2, t3, ep;
  logic [7:0]  char_code = 8'h00;
  logic [4:0]  char_height = 5'h00;
  logic [7:0]  ovl_tab [3] = '{8'h18, 8'h1C, 8'h0C};
  int          n_mismatch = 0, n_tests = 0, cyc = 0;

  loc_overlay_chargen loc_overlay_chargen_i (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .cmd_wr_i(cmd_wr), .cmd_code_i(cmd_code), .prm_wr_i(prm_wr),
    .prm_data_i(prm_data), .first_pix_i(px1),
    .first_from_blk3_i(blk3_src), .second_pix_i(px2),
    .third_pix_i(px3), .comp_pix_o(comp_pix),
    .char_code_i(char_code), .char_height_i(char_height),
    .cg_addr_o(cg_addr), .blk1_graphics_o(b1_g), .blk2_graphics_o(b2_g),
    .blk3_graphics_o(b3_g), .blk4_graphics_o(b4_g), .three_layer_o(three),
    .second_text_o(t2), .third_text_o(t3));

  loc_host_model loc_host_model_i (.sys_clk_i(sys_clk_i),
    .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .cmd_wr_o(cmd_wr),
    .cmd_code_o(cmd_code), .prm_wr_o(prm_wr), .prm_data_o(prm_data));

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  // Compare tasks
  task automatic chk_v(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_v(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    loc_host_model_i.rd(a, rv);
    chk_v($sformatf("reg %h", a), {8'h00, e}, {8'h00, rv});
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd_chk(`LOC_OFF_OVL_CTRL, 8'h00);
    rd_chk(`LOC_OFF_CG_LOW, 8'h00);
    rd_chk(`LOC_OFF_CG_HIGH, 8'h00);
    chk_b("blk2 gfx", 1'b1, b2_g);
    chk_b("blk4 gfx", 1'b1, b4_g);
    chk_b("second text", 1'b0, t2);
    chk_b("third text", 1'b0, t3);
    $display("test reset done");
    loc_host_model_i.wr(`LOC_OFF_OVL_CTRL, 8'hFF);
    rd_chk(`LOC_OFF_OVL_CTRL, 8'h1F);
    chk_b("three layer", 1'b1, three);
    loc_host_model_i.wr(`LOC_OFF_OVL_CTRL, 8'h08);
    rd_chk(16'h8020, 8'h00);
    chk_b("blk1 gfx", 1'b0, b1_g);
    chk_b("blk3 gfx", 1'b1, b3_g);
    chk_b("three layer", 1'b0, three);
    $display("test direct overlay done");
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 3; i++) begin
        loc_host_model_i.cmd(`LOC_CMD_OVERLAY);
        loc_host_model_i.prm(ovl_tab[i] | 8'(m));
        for (int k = 0; k < 2; k++) begin
          for (int p = 0; p < 8; p++) begin
            @(posedge sys_clk_i);
            {px1, px2, px3} <= 3'(p);
            blk3_src <= 1'(k);
            @(posedge sys_clk_i);
            #1;
            ep = (m == 1) ? (p[2] ^ p[1]) :
                 (m == 2) ? (p[2] & p[1]) : (p[2] | p[1]);
            ep = ep | (p[0] && (i == 1 || (i == 0 && k == 1)));
            chk_b("composed pixel", ep, comp_pix);
          end
        end
      end
    end
    rd_chk(`LOC_OFF_OVL_CTRL, 8'h0F);
    loc_host_model_i.cmd(`LOC_CMD_OVERLAY);
    loc_host_model_i.cmd(8'h00);
    loc_host_model_i.prm(8'h10);
    rd_chk(`LOC_OFF_OVL_CTRL, 8'h0F);
    $display("test composition done");
    @(posedge sys_clk_i);
    char_code   <= 8'h80;
    char_height <= 5'h08;
    loc_host_model_i.cmd(`LOC_CMD_CG_ADDR);
    loc_host_model_i.prm(8'h00);
    loc_host_model_i.prm(8'h60);
    loc_host_model_i.prm(8'hEE);
    rd_chk(`LOC_OFF_CG_LOW, 8'h00);
    rd_chk(`LOC_OFF_CG_HIGH, 8'h60);
    chk_v("pattern addr", 16'h6400, cg_addr);
    $display("test indirect address done");
    loc_host_model_i.wr(`LOC_OFF_CG_LOW, 8'h34);
    rd_chk(`LOC_OFF_CG_LOW, 8'h34);
    chk_v("pattern addr", 16'h6400, cg_addr);
    loc_host_model_i.wr(`LOC_OFF_CG_HIGH, 8'h12);
    @(posedge sys_clk_i);
    char_code   <= 8'hFF;
    char_height <= 5'h1F;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_v("pattern addr", 16'h3115, cg_addr);
    $display("test direct address done");
    final_report();
  end
endmodule
